// File: include/kpi_pkg.sv
// key pin interrupt unit: shared constants and carrier types
// assumes a 32-bit avalon-mm slave port with byte addresses
package kpi_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int KPI_NPIN = 6; // key pins on the port
    localparam int KPI_AW = 5; // byte address width
    localparam int KPI_DW = 32; // bus data width
    localparam int KPI_NEV = 2; // interrupt events
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [4:0] KPI_OFF_KSC = 5'h00; // key_status_control_reg
    localparam logic [4:0] KPI_OFF_PIE = 5'h04; // pin_irq_enable_reg
    localparam logic [4:0] KPI_OFF_PDAT = 5'h08; // port data
    localparam logic [4:0] KPI_OFF_PDIR = 5'h0C; // port direction
    localparam logic [4:0] KPI_OFF_ISTAT = 5'h10; // event status, w1c
    localparam logic [4:0] KPI_OFF_IMASK = 5'h14; // event mask
    // ----------------------------------------
    // key_status_control_reg fields
    // ----------------------------------------
    localparam int KPI_KSC_LVL = 0; // level_sense_select
    localparam int KPI_KSC_MASK = 1; // key_irq_mask
    localparam int KPI_KSC_ACK = 2; // ack_write_bit, reads zero
    localparam int KPI_KSC_PEND = 3; // key_pending_flag, read only
    localparam logic KPI_LVL_RST = 1'h0; // edge mode after reset
    localparam logic KPI_MASK_RST = 1'h0; // unmasked after reset
    // ----------------------------------------
    // event status bits and vector
    // ----------------------------------------
    localparam int KPI_EV_KEY = 0; // key request latched
    localparam int KPI_EV_WAKE = 1; // wake request latched
    localparam logic [15:0] KPI_VEC_ADDR = 16'hFFE0; // high byte, low at +1
    // ----------------------------------------
    // bus strobe carrier from slave to register file
    // ----------------------------------------
    typedef struct packed {
        logic wr; // one-cycle write strobe
        logic rd; // one-cycle read strobe
        logic [KPI_AW-1:0] addr; // byte address
        logic [KPI_DW-1:0] wdata; // write data
        logic be0; // low byte lane enabled
    } kpi_bus_req_t;
endpackage

// File: hdl/kpi_sync.sv
// key pin interrupt unit: two-flop pin synchroniser
// assumes pins change with no relation to ref_clk
`timescale 1ns/100ps
module kpi_sync #(
    parameter int W = kpi_pkg::KPI_NPIN
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import kpi_pkg::*;
    // state: first stage only feeds the second
    typedef struct packed {
        logic [W-1:0] s1; // metastable stage
        logic [W-1:0] s2; // settled stage
    } kpi_sync_t;
    kpi_sync_t st_r, st_nxt;
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q = st_r.s2;
endmodule

// File: hdl/kpi_avs.sv
// key pin interrupt unit: avalon-mm slave front end
// assumes master holds request until waitrequest is seen low
`timescale 1ns/100ps
module kpi_avs (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [kpi_pkg::KPI_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [kpi_pkg::KPI_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [kpi_pkg::KPI_DW-1:0] rd_data,
    output kpi_pkg::kpi_bus_req_t bus_req,
    output logic [kpi_pkg::KPI_DW-1:0] avs_readdata,
    output logic avs_waitrequest
);
    import kpi_pkg::*;
    // state: one wait cycle, then answer for one cycle
    typedef struct packed {
        logic wait_n; // high answers the held request
        logic [KPI_DW-1:0] rdata; // captured read data
        kpi_bus_req_t req; // strobes for register file
    } kpi_avs_t;
    kpi_avs_t st_r, st_nxt;
    // ----------------------------------------
    // accept one request, answer next cycle
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.wait_n = 1'b0;
        st_nxt.req = '0;
        // not while answering, so a held request is taken once
        if ((avs_read || avs_write) && !st_r.wait_n) begin
            st_nxt.wait_n = 1'b1;
            st_nxt.req.wr = avs_write;
            st_nxt.req.rd = avs_read;
            st_nxt.req.addr = avs_address;
            st_nxt.req.wdata = avs_writedata;
            st_nxt.req.be0 = avs_byteenable[0];
            // data is fixed now; a flag rising later shows next read
            st_nxt.rdata = avs_read ? rd_data : '0;
        end
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign bus_req = st_r.req;
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = !st_r.wait_n;
endmodule

// File: hdl/kpi_key_irq_unit.sv
// key pin interrupt unit: key_irq_unit top with registers
// assumes cpu vector fetch and wake request are ref_clk pulses
// Operation
// [R1] - level mode: edges and lows, ack plus high
// [R2] - vector fetch acknowledges, clears latched request
// [R3] - ack_write_bit one acts as vector fetch
// [R4] - ack write keeps edge detect; new edge latches
// [R5] - unmasked request taken, vector at FFE0/FFE1
// [R6] - level mode: request held while pin low
// [R7] - wake request cleared only by ack write
// [R8] - ack and release accepted in any order
// [R9] - edge mode: ack clears at once
// [R10] - reset clears request and level select
// [R11] - pending flag readable, ignores mask
// [R12] - pin enable forces pin to input
// [R13] - software keeps direction zero to read pin
// [R14] - keeps running in wait and stop
// [R15] - six per-pin enables select key inputs
// [R16] - synchronise; edge is high then low
// [R17] - cpu request is latch gated by mask
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module kpi_key_irq_unit #(
    parameter int NPIN = kpi_pkg::KPI_NPIN
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [kpi_pkg::KPI_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [kpi_pkg::KPI_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [kpi_pkg::KPI_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NPIN-1:0] key_pin_in,
    output logic [NPIN-1:0] key_pin_out,
    output logic [NPIN-1:0] key_pin_oe,
    input wire logic vector_fetch,
    input wire logic wake_timer_request,
    output logic key_irq_req,
    output logic [15:0] key_vector_addr,
    output logic irq
);
    import kpi_pkg::*;
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic lvl; // level_sense_select
        logic mask; // key_irq_mask
        logic [NPIN-1:0] pie; // pin_irq_enable
        logic [NPIN-1:0] pdat; // port data latch
        logic [NPIN-1:0] pdir; // port direction, one drives
        logic [NPIN-1:0] prev; // last synced pin sample
        logic key_lat; // latched key request
        logic wake_lat; // latched wake_timer_request
        logic ack_seen; // level mode: ack came, waits release
        logic [KPI_NEV-1:0] istat; // sticky event status
        logic [KPI_NEV-1:0] imask; // event mask
        logic irq; // event interrupt output
        logic key_req; // cpu request output
        logic [15:0] vec; // vector address output
        logic [NPIN-1:0] pin_out; // pin drive value
        logic [NPIN-1:0] pin_oe; // pin drive enable
    } kpi_state_t;
    kpi_state_t st_r, st_nxt;
    kpi_bus_req_t bus_req; // strobes from the slave
    logic [KPI_DW-1:0] rd_data; // read mux result
    logic [NPIN-1:0] pin_sync; // synchronised pins
    logic [NPIN-1:0] fall_bit; // per-pin falling edge
    logic [NPIN-1:0] low_bit; // per-pin enabled low
    logic fall; // any enabled falling edge
    logic any_low; // any enabled pin low
    logic sw_ack; // ack_write_bit written as one
    logic ack; // vector fetch or software ack
    logic pending; // key_pending_flag
    logic wr_ksc; // write to status/control
    // ----------------------------------------
    // submodules
    // ----------------------------------------
    // pins are asynchronous, two flops before any use
    kpi_sync #(
        .W(NPIN)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d(key_pin_in),
        .q(pin_sync)
    ); // [R16]
    kpi_avs u_avs (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .rd_data(rd_data),
        .bus_req(bus_req),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );
    // ----------------------------------------
    // per-pin edge and level terms
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            // only enabled pins take part [R15]
            assign fall_bit[gi] = st_r.pie[gi] && st_r.prev[gi] && !pin_sync[gi]; // [R16]
            assign low_bit[gi] = st_r.pie[gi] && !pin_sync[gi];
        end
    endgenerate
    assign fall = |fall_bit;
    assign any_low = |low_bit;
    assign wr_ksc = bus_req.wr && bus_req.be0 && (bus_req.addr == KPI_OFF_KSC);
    assign sw_ack = wr_ksc && bus_req.wdata[KPI_KSC_ACK]; // [R3]
    assign ack = vector_fetch || sw_ack; // [R2] [R3]
    assign pending = st_r.key_lat || st_r.wake_lat; // [R11]
    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rd_data = '0;
        // decode the live address: the slave captures at the accept edge
        case (avs_address)
            KPI_OFF_KSC: begin
                // pending shows regardless of mask [R11]
                rd_data[KPI_KSC_PEND] = pending;
                rd_data[KPI_KSC_MASK] = st_r.mask;
                rd_data[KPI_KSC_LVL] = st_r.lvl;
            end
            KPI_OFF_PIE: begin
                rd_data[NPIN-1:0] = st_r.pie;
            end
            KPI_OFF_PDAT: begin
                // pin level only where direction is zero [R13]
                rd_data[NPIN-1:0] = (st_r.pdir & st_r.pdat) | (~st_r.pdir & pin_sync);
            end
            KPI_OFF_PDIR: begin
                rd_data[NPIN-1:0] = st_r.pdir;
            end
            KPI_OFF_ISTAT: begin
                rd_data[KPI_NEV-1:0] = st_r.istat;
            end
            KPI_OFF_IMASK: begin
                rd_data[KPI_NEV-1:0] = st_r.imask;
            end
            default: begin
                // unmapped reads return zero
                rd_data = '0;
            end
        endcase
    end
    // the slave samples the mux while the request is held
    // ----------------------------------------
    // next state
    // ----------------------------------------
    // no clock gating here, so it runs in wait and stop [R14]
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = pin_sync; // [R16]
        // register writes, low byte lane only
        if (bus_req.wr && bus_req.be0) begin
            case (bus_req.addr)
                KPI_OFF_KSC: begin
                    st_nxt.lvl = bus_req.wdata[KPI_KSC_LVL];
                    st_nxt.mask = bus_req.wdata[KPI_KSC_MASK];
                end
                KPI_OFF_PIE: begin
                    st_nxt.pie = bus_req.wdata[NPIN-1:0]; // [R15]
                end
                KPI_OFF_PDAT: begin
                    st_nxt.pdat = bus_req.wdata[NPIN-1:0];
                end
                KPI_OFF_PDIR: begin
                    st_nxt.pdir = bus_req.wdata[NPIN-1:0];
                end
                KPI_OFF_ISTAT: begin
                    // write one clears; set below wins
                    st_nxt.istat = st_r.istat & ~bus_req.wdata[KPI_NEV-1:0];
                end
                KPI_OFF_IMASK: begin
                    st_nxt.imask = bus_req.wdata[KPI_NEV-1:0];
                end
                default: begin
                    // unmapped writes are dropped
                    st_nxt.istat = st_nxt.istat;
                end
            endcase
        end
        // key request latch
        if (!st_r.lvl) begin
            // edge mode: ack clears at once, new edge wins [R9]
            if (fall) begin
                st_nxt.key_lat = 1'b1; // [R4]
            end else if (ack) begin
                st_nxt.key_lat = 1'b0; // [R2] [R9]
            end
            st_nxt.ack_seen = 1'b0;
        end else begin
            // level mode: low holds, clear needs ack and release [R1]
            if (fall || any_low) begin
                st_nxt.key_lat = 1'b1; // [R6]
                // a fresh edge needs a fresh ack [R4]
                if (fall) begin
                    st_nxt.ack_seen = 1'b0;
                end else if (ack && st_r.key_lat) begin
                    st_nxt.ack_seen = 1'b1; // [R8]
                end
            end else if (ack || st_r.ack_seen) begin
                // all enabled pins high, ack now or before [R8]
                st_nxt.key_lat = 1'b0;
                st_nxt.ack_seen = 1'b0;
            end
        end
        // wake latch: only the ack write clears it [R7]
        if (wake_timer_request) begin
            st_nxt.wake_lat = 1'b1;
        end else if (sw_ack) begin
            st_nxt.wake_lat = 1'b0; // [R7]
        end
        // sticky events, set wins over the w1c clear
        if (!st_r.key_lat && st_nxt.key_lat) begin
            st_nxt.istat[KPI_EV_KEY] = 1'b1;
        end
        if (wake_timer_request) begin
            st_nxt.istat[KPI_EV_WAKE] = 1'b1;
        end
        st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
        // cpu request: pending gated by mask [R17] [R5]
        st_nxt.key_req = (st_nxt.key_lat || st_nxt.wake_lat) && !st_nxt.mask;
        st_nxt.vec = KPI_VEC_ADDR; // [R5]
        // enabled pin never drives [R12]
        st_nxt.pin_oe = st_nxt.pdir & ~st_nxt.pie;
        st_nxt.pin_out = st_nxt.pdat;
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // request and level select clear whatever the pins [R10]
            st_r <= '0;
            st_r.lvl <= KPI_LVL_RST; // [R10]
            st_r.mask <= KPI_MASK_RST;
            st_r.vec <= KPI_VEC_ADDR;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign key_pin_out = st_r.pin_out;
    assign key_pin_oe = st_r.pin_oe;
    assign key_irq_req = st_r.key_req;
    assign key_vector_addr = st_r.vec;
    assign irq = st_r.irq;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    chk_level_hold: assert property (st_r.lvl && any_low |=> st_r.key_lat) // [R6]
        else $error("level mode request dropped while pin low");
    chk_edge_ack: assert property (!st_r.lvl && ack && !fall |=> !st_r.key_lat) // [R9]
        else $error("edge mode ack did not clear request");
    chk_fall_latch: assert property (fall
        |=> st_r.key_lat && (st_r.istat[KPI_EV_KEY] || $past(st_r.key_lat))) // [R4]
        else $error("falling edge not latched");
    chk_wake_keep: assert property (st_r.wake_lat && !sw_ack |=> st_r.wake_lat) // [R7]
        else $error("wake request cleared without ack write");
    chk_wake_ack: assert property (sw_ack && !wake_timer_request |=> !st_r.wake_lat) // [R3]
        else $error("ack write left wake request set");
    chk_level_order: assert property (st_r.lvl && st_r.ack_seen && !any_low
        |=> !st_r.key_lat) // [R8]
        else $error("release after ack did not clear request");
    // request output and latch are registered on the same edge
    chk_req_gate: assert property (st_r.key_lat && !st_r.mask |-> key_irq_req) // [R17]
        else $error("unmasked request not presented");
    chk_mask_block: assert property (st_r.mask |-> !key_irq_req) // [R17]
        else $error("masked request reached cpu");
    // drive enable and pin enable are registered together
    chk_pin_input: assert property ((key_pin_oe & st_r.pie) == '0) // [R12]
        else $error("enabled key pin is driven");
    chk_vec_fixed: assert property (key_vector_addr == KPI_VEC_ADDR) // [R5]
        else $error("vector address wrong");
    cov_edge_req: cover property (!st_r.lvl && fall ##1 key_irq_req);
    cov_level_clear: cover property (st_r.lvl && st_r.ack_seen ##[1:20] !st_r.key_lat);
    cov_wake_ack: cover property (st_r.wake_lat ##1 sw_ack ##1 !st_r.wake_lat);
    cov_irq: cover property (irq && bus_req.wr && bus_req.addr == KPI_OFF_ISTAT);
endmodule

// File: sim/kpi_key_model.sv
// key pin interrupt unit: model of the key switches on the port pins
// assumes a pull-up on every pin and that the bench names the held keys
`timescale 1ns/100ps
module kpi_key_model (
    input wire logic [5:0] press,
    input wire logic [5:0] key_pin_out,
    input wire logic [5:0] key_pin_oe,
    output logic [5:0] key_pin_in
);
    // ----------------------------------------
    // pin level
    // ----------------------------------------
    // unit drive wins, a held key pulls low, else the pull-up
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            key_pin_in[i] = key_pin_oe[i] ? key_pin_out[i] : ~press[i];
        end
    end
endmodule

// File: sim/tb_top.sv
// key pin interrupt unit: self-checking bench with a behavioural model
// assumes the unit answers avalon-mm requests after its own wait cycle
`timescale 1ns/100ps
module tb_top;
    import kpi_pkg::*;
    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic ref_clk, reset_n, avs_read, avs_write, vector_fetch, wake_timer_request;
    logic [KPI_AW-1:0] avs_address;
    logic [KPI_DW-1:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, key_irq_req, irq;
    logic [5:0] key_pin_in, key_pin_out, key_pin_oe, press;
    logic [15:0] key_vector_addr;
    logic [7:0] rnd, pdat; // lfsr state, port latch
    int error_cnt, check_count, cyc;
    logic m_key, m_wake, m_lvl, m_mask, m_ackp; // model latches
    logic [5:0] m_pie, m_prs; // enables, held keys
    logic [1:0] m_ist, m_imsk; // event status and mask
    kpi_key_irq_unit u_kpi_key_irq_unit (.ref_clk(ref_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .key_pin_in(key_pin_in), .key_pin_out(key_pin_out), .key_pin_oe(key_pin_oe),
        .vector_fetch(vector_fetch), .wake_timer_request(wake_timer_request),
        .key_irq_req(key_irq_req), .key_vector_addr(key_vector_addr), .irq(irq));
    kpi_key_model u_kpi_key_model (.press(press), .key_pin_out(key_pin_out),
        .key_pin_oe(key_pin_oe), .key_pin_in(key_pin_in));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one avalon transfer; an edge passes first so no signal is set twice
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50) error_cnt++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wksc(input logic a);
        bus(1'b1, KPI_OFF_KSC, {29'h0, a, m_mask, m_lvl});
    endtask
    // press or release one key and update the model latch
    task automatic key(input int i, input logic dn);
        @(posedge ref_clk);
        if (dn && m_pie[i] && !m_key) m_ist[0] = 1'b1;
        if (dn && m_pie[i]) m_key = 1'b1;
        m_prs[i] = dn;
        press <= m_prs;
        if (m_lvl && m_ackp && (m_prs & m_pie) == 6'h00) begin
            m_key = 1'b0;
            m_ackp = 1'b0;
        end
    endtask
    // acknowledge by write (sw) or by vector fetch pulse
    task automatic ack(input logic sw);
        if (sw) wksc(1'b1);
        else begin
            @(posedge ref_clk);
            vector_fetch <= 1'b1;
            @(posedge ref_clk);
            vector_fetch <= 1'b0;
        end
        if (m_key && (!m_lvl || (m_prs & m_pie) == 6'h00)) m_key = 1'b0;
        else if (m_key) m_ackp = 1'b1;
        if (sw) m_wake = 1'b0;
    endtask
    // let the synchroniser settle, then compare request, irq, status/control and event status
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        chk(key_irq_req, (m_key || m_wake) && !m_mask);
        chk(irq, |(m_ist & m_imsk));
        bus(1'b0, KPI_OFF_KSC, 32'h0);
        chk(rd, {28'h0, m_key | m_wake, 1'b0, m_mask, m_lvl});
        bus(1'b0, KPI_OFF_ISTAT, 32'h0);
        chk(rd, {30'h0, m_ist});
    endtask
    task automatic mreset();
        {m_key, m_wake, m_lvl, m_mask, m_ackp} = 5'h0;
        {m_pie, m_ist, m_imsk} = 10'h0;
    endtask
    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // a hang counts as a mismatch
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        {avs_read, avs_write, vector_fetch, wake_timer_request} = 4'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        press = 6'h00;
        m_prs = 6'h00;
        rnd = 8'h04;
        mreset();
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle();
        chk(key_vector_addr, KPI_VEC_ADDR);
        bus(1'b0, 5'h18, 32'h0);
        chk(rd, 32'h0);
        // random port latch and enables; enabled pins lose their drive
        rnd = lfsr(rnd);
        pdat = rnd;
        bus(1'b1, KPI_OFF_PDAT, {24'h0, pdat});
        bus(1'b1, KPI_OFF_PDIR, 32'h3F);
        rnd = lfsr(rnd);
        m_pie = rnd[5:0];
        bus(1'b1, KPI_OFF_PIE, {26'h0, m_pie});
        bus(1'b0, KPI_OFF_PDAT, 32'h0);
        chk(rd, {26'h0, pdat[5:0]});
        chk(key_pin_oe, {26'h0, ~m_pie});
        chk(key_pin_out, {26'h0, pdat[5:0]});
        bus(1'b1, KPI_OFF_PDIR, 32'h0);
        key(1, 1'b1);
        repeat (4) @(posedge ref_clk);
        bus(1'b0, KPI_OFF_PDAT, 32'h0);
        chk(rd, 32'h3D);
        key(1, 1'b0);
        ack(1'b1);
        m_pie = 6'h3E;
        bus(1'b1, KPI_OFF_PIE, 32'h3E);
        settle();
        // disabled pin stays quiet
        key(0, 1'b1);
        settle();
        key(0, 1'b0);
        // edge mode on every enabled pin, both kinds of acknowledge
        for (int i = 1; i < 6; i++) begin
            key(i, 1'b1);
            settle();
            ack(i[0]);
            settle();
            key(i, 1'b0);
        end
        // ack while held, then a fresh edge latches again
        // let the press latch first: an edge in the ack cycle wins
        key(2, 1'b1);
        settle();
        ack(1'b1);
        settle();
        key(2, 1'b0);
        key(2, 1'b1);
        settle();
        ack(1'b0);
        key(2, 1'b0);
        // masked request still pending; status irq enabled, raised, cleared
        m_mask = 1'b1;
        wksc(1'b0);
        m_imsk = 2'h1;
        bus(1'b1, KPI_OFF_IMASK, 32'h1);
        key(3, 1'b1);
        settle();
        m_ist[0] = 1'b0;
        bus(1'b1, KPI_OFF_ISTAT, 32'h1);
        settle();
        m_mask = 1'b0;
        wksc(1'b0);
        settle();
        ack(1'b0);
        key(3, 1'b0);
        // wake request survives a vector fetch
        m_imsk = 2'h3;
        bus(1'b1, KPI_OFF_IMASK, 32'h3);
        @(posedge ref_clk);
        wake_timer_request <= 1'b1;
        @(posedge ref_clk);
        wake_timer_request <= 1'b0;
        m_wake = 1'b1;
        m_ist[1] = 1'b1;
        settle();
        ack(1'b0);
        settle();
        ack(1'b1);
        settle();
        // level mode, acknowledge before and after release
        m_lvl = 1'b1;
        wksc(1'b0);
        key(4, 1'b1);
        settle();
        ack(1'b0);
        settle();
        key(4, 1'b0);
        settle();
        key(5, 1'b1);
        key(5, 1'b0);
        settle();
        ack(1'b1);
        settle();
        // reset mid-run with a key held low
        key(1, 1'b1);
        settle();
        reset_n <= 1'b0;
        mreset();
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle();
        m_pie = 6'h3E;
        bus(1'b1, KPI_OFF_PIE, 32'h3E);
        settle();
        key(1, 1'b0);
        settle();
        conclude();
    end
endmodule
